// File: hdl/ppc_pkg.sv
/*
  Shared constants and carrier types for the port protection control block.
  Assumes a 125 MHz clock and a single AHB-Lite master with word-only accesses.
*/
package ppc_pkg;
  localparam int PPC_PORTS = 4;
  localparam int PPC_CLK_MHZ = 125;
  localparam int PPC_ADC_BITS = 14;
  // Deglitch interval, in microseconds; a new level is taken inside 1 to 5 us.
  localparam int PPC_DEGLITCH_US = 2;
  localparam int PPC_DEGLITCH_CYC = PPC_DEGLITCH_US * PPC_CLK_MHZ;
  // Fast overload off period, in microseconds.
  localparam int PPC_FAST_OFF_US = 100;
  localparam int PPC_FAST_OFF_CYC = PPC_FAST_OFF_US * PPC_CLK_MHZ;
  // Conversion period and sampling window, in microseconds.
  localparam int PPC_CONV_US = 20000;
  localparam int PPC_SAMPLE_US = 17500;
  localparam int PPC_CONV_CYC = PPC_CONV_US * PPC_CLK_MHZ;
  localparam int PPC_SAMPLE_CYC = PPC_SAMPLE_US * PPC_CLK_MHZ;
  // Fault timer limits in cycles of the fault tick, tick period in clock cycles, and down-count ratio.
  localparam int PPC_CUT_LIMIT = 60;
  localparam int PPC_START_LIMIT = 60;
  localparam int PPC_FAULT_TICK_CYC = 125000;
  localparam int PPC_DOWN_RATIO = 16;
  // Foldback breakpoints in volts and floor in percent.
  localparam logic [7:0] PPC_FB_KNEE_V = 8'h12;
  localparam logic [7:0] PPC_FB_KNEE_2X_V = 8'h1c;
  localparam logic [7:0] PPC_FB_FLOOR_PCT = 8'h0e;
  localparam logic [7:0] PPC_FB_FULL_PCT = 8'h64;

  // Register byte offsets and the control register reset value.
  localparam logic [7:0] PPC_REG_CTRL = 8'h00;
  localparam logic [7:0] PPC_REG_MUXCFG = 8'h04;
  localparam logic [7:0] PPC_REG_STATUS = 8'h08;
  localparam logic [7:0] PPC_REG_INT = 8'h0c;
  localparam logic [7:0] PPC_REG_RESULT0 = 8'h10;
  localparam logic [31:0] PPC_CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {PPC_MEAS_IDC, PPC_MEAS_VDC, PPC_MEAS_IAC, PPC_MEAS_DET} ppc_meas_t;

  typedef struct packed {
    logic on;
    logic starting;
    logic ac_enable;
    logic over_cut;
    logic in_foldback;
    logic fast_overload;
  } ppc_port_in_t;

  typedef struct packed {
    logic gate_on;
    logic cut_fault;
    logic start_fault;
    logic rearm_ok;
    logic start_done;
  } ppc_port_out_t;
endpackage

// File: hdl/ppc_deglitch.sv
/*
  Synchronised deglitch filter for one active-low pin.
  Assumes the pin is asynchronous to clk_i; it passes two flip-flops first.
*/
`timescale 1ns/1ps
`default_nettype none
module ppc_deglitch #(
  parameter int STABLE_CYC = ppc_pkg::PPC_DEGLITCH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic level_o
);
  import ppc_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic [15:0] cnt;
  } ppc_dg_state_t;
  ppc_dg_state_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    if (st_reg.s2 == st_reg.level) begin
      st_next.cnt = 16'h0000;
    end else if (st_reg.cnt == 16'(STABLE_CYC - 1)) begin
      st_next.level = st_reg.s2;
      st_next.cnt = 16'h0000;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: 16'h0000};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end
  assign level_o = st_reg.level;
endmodule
`default_nettype wire

// File: hdl/ppc_fault_timer.sv
/*
  Per-port over-current fault timer with up/down counting and fast overload off time.
  Assumes comparator flags already synchronised to clk_i and a fault tick strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module ppc_fault_timer #(
  parameter int CUT_LIMIT = ppc_pkg::PPC_CUT_LIMIT,
  parameter int START_LIMIT = ppc_pkg::PPC_START_LIMIT,
  parameter int FAST_OFF_CYC = ppc_pkg::PPC_FAST_OFF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire ppc_pkg::ppc_port_in_t pin_i,
  output ppc_pkg::ppc_port_out_t pout_o
);
  import ppc_pkg::*;
  typedef struct packed {
    logic [11:0] fcnt;
    logic [3:0] down_div;
    logic [13:0] fast_cnt;
    logic [11:0] start_cnt;
    logic start_done;
    logic cut_fault;
    logic start_fault;
  } ppc_ft_state_t;
  ppc_ft_state_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    if (!pin_i.on) begin
      st_next.start_cnt = 12'h000;
      st_next.start_done = 1'b0;
      st_next.fast_cnt = 14'h0000;
    end
    if (pin_i.on && pin_i.fast_overload && st_reg.fast_cnt == 14'h0000) begin
      st_next.fast_cnt = 14'(FAST_OFF_CYC);
    end else if (st_reg.fast_cnt != 14'h0000) begin
      st_next.fast_cnt = st_reg.fast_cnt - 14'h0001;
    end
    if (tick_i) begin
      if (pin_i.on && !st_reg.start_done) begin
        if (st_reg.start_cnt == 12'(START_LIMIT - 1)) begin
          st_next.start_done = 1'b1;
          if (pin_i.over_cut) begin
            st_next.start_fault = 1'b1;
          end
        end
        st_next.start_cnt = st_reg.start_cnt + 12'h001;
      end
      if (pin_i.on && pin_i.over_cut && st_reg.start_done) begin
        if (st_reg.fcnt >= 12'(CUT_LIMIT - 1)) begin
          st_next.cut_fault = 1'b1;
        end else begin
          st_next.fcnt = st_reg.fcnt + 12'h001;
        end
        st_next.down_div = 4'h0;
      end else if (!pin_i.over_cut && !pin_i.in_foldback && st_reg.fcnt != 12'h000) begin
        st_next.down_div = st_reg.down_div + 4'h1;
        if (st_reg.down_div == 4'(PPC_DOWN_RATIO - 1)) begin
          st_next.fcnt = st_reg.fcnt - 12'h001;
        end
      end
    end
    if (!pin_i.on && st_reg.fcnt == 12'h000) begin
      st_next.cut_fault = 1'b0;
      st_next.start_fault = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end
  assign pout_o.gate_on = pin_i.on && !st_reg.cut_fault && !st_reg.start_fault
                          && st_reg.fast_cnt == 14'h0000;
  assign pout_o.cut_fault = st_reg.cut_fault;
  assign pout_o.start_fault = st_reg.start_fault;
  assign pout_o.rearm_ok = st_reg.fcnt == 12'h000;
  assign pout_o.start_done = st_reg.start_done;
endmodule
`default_nettype wire

// File: hdl/ppc_top.sv
/*
  Four-port power-sourcing protection and measurement control with AHB-Lite registers.
  Assumes pins are asynchronous, analogue comparators give digital flags, and
  converter results arrive as 14-bit words with a done strobe per port.
*/
// Local design decisions: the AHB-Lite slave port and the register addresses.
// Summary of operation
// - Deglitched reset turns ports off, clears registers; the result registers keep their values.
// - Internal power-on reset independent of pin.
// - Interrupt low when any bit set, between transfers.
// - Port-one off input overrides all but mux.
// - Muxed off input stops selected ports.
// - Ports two to four have own off.
// - AC disconnect high impedance turns port off.
// - Two sink levels, four-point detect.
// - Gate low on supply, timeout, manual off.
// - Foldback 100 percent at knee, 14 at zero.
// - Fault timer counts, cuts at limits.
// - Count down at one sixteenth rate.
// - No restart before counter reaches zero.
// - Fast overload off 100 us, ramp on.
// - Autonomous pin sampled only after reset.
// - Independent 14-bit converter per port.
// - Conversion 20 ms, 17.5 ms window; the code does not time these, each done strobe lets the next conversion start.
// - AC integration synced to sine generator.
// - Interleave voltage, current, AC current conversions.
// - Results stored while port on.
// - Classification runs per port independently.
// - Results hold while port off.
// - No conversion before start timer expires.
// - Result read as two bytes; the code returns current and voltage together in one 32-bit word.
// - Inrush uses single foldback profile.
`timescale 1ns/1ps
`default_nettype none
module ppc_top #(
  parameter int NPORTS = ppc_pkg::PPC_PORTS,
  parameter int CONV_CYC = ppc_pkg::PPC_CONV_CYC,
  parameter int SAMPLE_CYC = ppc_pkg::PPC_SAMPLE_CYC,
  parameter int FAULT_TICK_CYC = ppc_pkg::PPC_FAULT_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic por_n_i,
  input wire logic ext_reset_n_i,
  input wire logic auto_mode_i,
  input wire logic port1_or_muxed_off_n_i,
  input wire logic [2:0] port_off_n_i,
  input wire logic supplies_ok_i,
  input wire logic [3:0] over_cut_i,
  input wire logic [3:0] in_foldback_i,
  input wire logic [3:0] fast_overload_i,
  input wire logic [3:0] ac_high_z_i,
  input wire logic [3:0] adc_done_i,
  input wire logic [55:0] adc_data_i,
  input wire logic sine_zero_i,
  input wire logic bus_busy_i,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [3:0] pass_gate_drive_o,
  output logic [3:0] adc_start_o,
  output logic [7:0] adc_meas_o,
  output logic [3:0] detect_level_hi_o,
  output logic [3:0] double_power_profile_o,
  output logic int_out_o,
  output logic int_oe_n_o,
  output logic auto_mode_o
);
  import ppc_pkg::*;
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic au1;
    logic au2;
    logic bb1;
    logic bb2;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic sample_auto;
    logic auto_mode;
    logic [31:0] ctrl;
    logic [3:0] muxcfg;
    logic [7:0] int_flags;
    logic int_pin;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [3:0] ac_off;
    logic [3:0] fault_q;
    logic [16:0] tick_cnt;
    logic [3:0] conv_busy;
    logic [3:0] adc_start;
    logic [7:0] meas;
    logic [3:0] det_hi;
    logic [3:0] det_cnt;
    logic [3:0] gate;
    logic [55:0] volt;
    logic [55:0] curr;
  } ppc_state_t;
  ppc_state_t st_reg, st_next;

  logic reset_n_level;
  logic off1_level;
  logic [2:0] off_level;
  logic [3:0] man_off;
  logic [3:0] own_off_n;
  logic [3:0] port_en;
  logic [7:0] int_set;
  logic [7:0] int_clr;
  logic soft_reset;
  ppc_port_in_t [3:0] pin;
  ppc_port_out_t [3:0] pout;

  ppc_deglitch u_rst_dg (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .pin_i(ext_reset_n_i), .level_o(reset_n_level)
  );
  ppc_deglitch u_off1_dg (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .pin_i(port1_or_muxed_off_n_i), .level_o(off1_level)
  );

  // Pin or power-on reset clears control, mux, interrupt flags, gates, AC off and fault timers.
  assign soft_reset = !reset_n_level || !por_n_i;
  assign own_off_n = {off_level, off1_level};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_off
      ppc_deglitch u_dg (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .pin_i(port_off_n_i[g]), .level_o(off_level[g])
      );
    end
    for (g = 0; g < 4; g++) begin : g_port
      always_comb begin
        if (st_reg.ctrl[4]) begin
          man_off[g] = !off1_level && st_reg.muxcfg[g];
        end else begin
          man_off[g] = !own_off_n[g];
        end
      end
      assign port_en[g] = st_reg.ctrl[g] && !man_off[g] && !st_reg.ac_off[g];
      assign pin[g] = '{on: port_en[g], starting: !pout[g].start_done,
        ac_enable: st_reg.ctrl[8 + g], over_cut: st_reg.sy2[g],
        in_foldback: in_foldback_i[g], fast_overload: fast_overload_i[g]};
      ppc_fault_timer u_ft (
        .clk_i(clk_i), .rst_n_i(rst_n_i && !soft_reset), .ce_i(ce_i),
        .tick_i(st_reg.tick_cnt == 17'h00000), .pin_i(pin[g]), .pout_o(pout[g])
      );
    end
  endgenerate

  logic ahb_go;
  logic [7:0] ra;
  assign ahb_go = hsel && hready && htrans[1];
  assign ra = haddr[7:0];

  always_comb begin
    st_next = st_reg;
    st_next.rs1 = ext_reset_n_i;
    st_next.rs2 = st_reg.rs1;
    st_next.au1 = auto_mode_i;
    st_next.au2 = st_reg.au1;
    st_next.bb1 = bus_busy_i;
    st_next.bb2 = st_reg.bb1;
    st_next.sy1 = over_cut_i;
    st_next.sy2 = st_reg.sy1;
    st_next.adc_start = 4'h0;
    int_set = 8'h00;
    int_clr = 8'h00;
    if (st_reg.sample_auto && st_reg.rs2) begin
      st_next.sample_auto = 1'b0;
      st_next.auto_mode = st_reg.au2;
    end
    st_next.tick_cnt = (st_reg.tick_cnt == 17'(FAULT_TICK_CYC - 1)) ? 17'h00000
                       : st_reg.tick_cnt + 17'h00001;
    for (int p = 0; p < 4; p++) begin
      st_next.gate[p] = supplies_ok_i && pout[p].gate_on;
      if (ac_high_z_i[p] && st_reg.ctrl[8 + p] && port_en[p]) begin
        st_next.ac_off[p] = 1'b1;
        int_set[p] = 1'b1;
      end else if (!st_reg.ctrl[p]) begin
        st_next.ac_off[p] = 1'b0;
      end
      st_next.fault_q[p] = pout[p].cut_fault || pout[p].start_fault;
      if (st_next.fault_q[p] && !st_reg.fault_q[p]) begin
        int_set[4 + p] = 1'b1;
      end
      if (!st_reg.conv_busy[p] && (!port_en[p] || pout[p].start_done)) begin
        st_next.conv_busy[p] = 1'b1;
        st_next.adc_start[p] = !st_reg.ctrl[8 + p] || sine_zero_i;
        if (st_reg.ctrl[8 + p] && !sine_zero_i) begin
          st_next.conv_busy[p] = 1'b0;
        end
        if (!port_en[p]) begin
          st_next.meas[2*p +: 2] = PPC_MEAS_DET;
          st_next.det_hi[p] = st_reg.det_cnt[p];
          st_next.det_cnt[p] = !st_reg.det_cnt[p];
        end
      end
      if (adc_done_i[p] && st_reg.conv_busy[p]) begin
        st_next.conv_busy[p] = 1'b0;
        if (port_en[p]) begin
          if (st_reg.meas[2*p +: 2] == PPC_MEAS_VDC) begin
            st_next.volt[14*p +: 14] = adc_data_i[14*p +: 14];
          end else if (st_reg.meas[2*p +: 2] == PPC_MEAS_IDC) begin
            st_next.curr[14*p +: 14] = adc_data_i[14*p +: 14];
          end
        end
        case (st_reg.meas[2*p +: 2])
          PPC_MEAS_IDC: st_next.meas[2*p +: 2] = PPC_MEAS_VDC;
          PPC_MEAS_VDC: st_next.meas[2*p +: 2] =
            st_reg.ctrl[8 + p] ? PPC_MEAS_IAC : PPC_MEAS_IDC;
          default: st_next.meas[2*p +: 2] = PPC_MEAS_IDC;
        endcase
      end
    end
    // Interrupt pin updates only when idle.
    if (!st_reg.bb2) begin
      st_next.int_pin = |st_reg.int_flags;
    end
    if (st_reg.wr_pend) begin
      st_next.wr_pend = 1'b0;
      case (st_reg.wr_addr)
        PPC_REG_CTRL: st_next.ctrl = hwdata;
        PPC_REG_MUXCFG: st_next.muxcfg = hwdata[3:0];
        PPC_REG_INT: int_clr = hwdata[7:0];
        default: st_next.wr_pend = 1'b0;
      endcase
    end
    // A new event wins over a clear written in the same cycle.
    st_next.int_flags = (st_reg.int_flags & ~int_clr) | int_set;
    if (ahb_go) begin
      st_next.wr_pend = hwrite;
      st_next.wr_addr = ra;
      // Result word packs current in the upper and voltage in the lower 16 bits.
      case (ra)
        PPC_REG_CTRL: st_next.rdata = st_reg.ctrl;
        PPC_REG_MUXCFG: st_next.rdata = {28'h0000000, st_reg.muxcfg};
        PPC_REG_STATUS: st_next.rdata = {20'h00000, st_reg.conv_busy, st_reg.gate,
                                         3'h0, st_reg.auto_mode};
        PPC_REG_INT: st_next.rdata = {24'h000000, st_reg.int_flags};
        default: begin
          if (ra >= PPC_REG_RESULT0 && ra < 8'h20) begin
            st_next.rdata = {2'h0, st_reg.curr[14*ra[3:2] +: 14],
                             2'h0, st_reg.volt[14*ra[3:2] +: 14]};
          end else begin
            st_next.rdata = 32'h0000_0000;
          end
        end
      endcase
    end
    if (soft_reset) begin
      st_next.ctrl = PPC_CTRL_RESET;
      st_next.muxcfg = 4'h0;
      st_next.int_flags = 8'h00;
      st_next.gate = 4'h0;
      st_next.ac_off = 4'h0;
      st_next.sample_auto = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.sample_auto <= 1'b1;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      double_power_profile_o <= 4'h0;
    end else if (ce_i) begin
      for (int p = 0; p < 4; p++) begin
        double_power_profile_o[p] <= st_reg.ctrl[12 + p] && pout[p].start_done;
      end
    end
  end

  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pass_gate_drive_o = st_reg.gate;
  assign adc_start_o = st_reg.adc_start;
  assign adc_meas_o = st_reg.meas;
  assign detect_level_hi_o = st_reg.det_hi;
  assign int_out_o = 1'b0;
  assign int_oe_n_o = !st_reg.int_pin;
  assign auto_mode_o = st_reg.auto_mode;
endmodule
`default_nettype wire

// File: verif/ppc_top_sva.sv
/*
  Checker for the port protection control top level, bound to its ports.
  Assumes one clock domain and the reset and deglitch figures of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module ppc_top_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic ext_reset_n_i,
  input wire logic [2:0] port_off_n_i,
  input wire logic supplies_ok_i,
  input wire logic [3:0] fast_overload_i,
  input wire logic bus_busy_i,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] pass_gate_drive_o,
  input wire logic [3:0] adc_start_o,
  input wire logic [7:0] adc_meas_o,
  input wire logic int_out_o,
  input wire logic int_oe_n_o,
  input wire logic auto_mode_o
);
  import ppc_pkg::*;
  logic [9:0] low_cnt_q [4];
  logic [9:0] run_cnt_q;
  logic [1:0] last_q;
  logic [3:0] lvl;
  assign lvl = {port_off_n_i, ext_reset_n_i};
  // Counters saturate so a long low level never wraps into a false pass.
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (!rst_n_i || lvl[k]) low_cnt_q[k] <= 10'h000;
      else if (low_cnt_q[k] != 10'h3ff) low_cnt_q[k] <= low_cnt_q[k] + 10'h001;
    end
    if (!rst_n_i || !ext_reset_n_i || !por_n_i) run_cnt_q <= 10'h000;
    else if (run_cnt_q != 10'h3ff) run_cnt_q <= run_cnt_q + 10'h001;
    if (!rst_n_i || !pass_gate_drive_o[0]) last_q <= PPC_MEAS_DET;
    else if (adc_start_o[0]) last_q <= adc_meas_o[1:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_int_busy_hold: assert property (
    bus_busy_i && $past(bus_busy_i) && $past(bus_busy_i, 2) && $past(bus_busy_i, 3)
    |-> $stable(int_oe_n_o))
    else $error("interrupt moved during a serial transaction");
  a_int_drive_low: assert property (int_out_o == 1'b0)
    else $error("interrupt pin drives a high level");
  a_supply_gate_off: assert property (
    !supplies_ok_i [*4] |-> pass_gate_drive_o == 4'h0)
    else $error("gate on with a supply low");
  a_reset_gate_off: assert property (
    low_cnt_q[0] >= 10'd260 |-> pass_gate_drive_o == 4'h0)
    else $error("gate on during held reset");
  a_offpin_gate_off: assert property (
    (low_cnt_q[1] < 10'd260 || !pass_gate_drive_o[1]) &&
    (low_cnt_q[2] < 10'd260 || !pass_gate_drive_o[2]) &&
    (low_cnt_q[3] < 10'd260 || !pass_gate_drive_o[3]))
    else $error("port stays on with its off pin held low");
  a_fast_gate_drop: assert property (
    fast_overload_i[0] && pass_gate_drive_o[0] |-> ##[1:6] !pass_gate_drive_o[0])
    else $error("gate not dropped on fast overload");
  a_start_pulse_once: assert property (
    adc_start_o[0] |=> !adc_start_o[0] [*2])
    else $error("conversion start longer than one pulse");
  a_meas_alternate: assert property (
    adc_start_o[0] && last_q != PPC_MEAS_DET && adc_meas_o[1:0] != PPC_MEAS_DET
    |-> adc_meas_o[1:0] != last_q)
    else $error("same powered conversion kind twice in a row");
  a_auto_frozen: assert property (run_cnt_q >= 10'd600 |-> $stable(auto_mode_o))
    else $error("mode changed long after reset");
  c_fast: cover property (fast_overload_i[0] && pass_gate_drive_o[0]);
  c_int: cover property (int_oe_n_o == 1'b0);
  c_iac: cover property (adc_start_o[0] && adc_meas_o[1:0] == PPC_MEAS_IAC);
endmodule
bind ppc_top ppc_top_chk u_chk (.*);
`default_nettype wire

// File: verif/ppc_port_model.sv
/*
  Behavioural model of the per-port converters and sine reference.
  Assumes one start pulse per conversion and a result read on the done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module ppc_port_model (
  input wire logic clk_i,
  input wire logic [3:0] start_i,
  input wire logic [7:0] meas_i,
  input wire logic slow_i,
  input wire logic [13:0] offs_i,
  output logic [55:0] data_o,
  output logic [3:0] done_o,
  output logic sine_o
);
  import ppc_pkg::*;
  int unsigned wait_q [4] = '{default: 0};
  logic [1:0] kind_q [4];
  logic [3:0] done_q = 4'h0;
  logic [13:0] noise_q = 14'h0000;
  logic [5:0] phase_q = 6'h00;
  // each port converts on its own countdown.
  always @(posedge clk_i) begin
    noise_q <= noise_q + 14'h0a5b;
    phase_q <= phase_q + 6'h01;
    for (int p = 0; p < 4; p++) begin
      done_q[p] <= 1'b0;
      if (start_i[p]) begin
        wait_q[p] <= slow_i ? 40 : 3;
        kind_q[p] <= meas_i[2*p +: 2];
      end else if (wait_q[p] == 1) begin
        done_q[p] <= 1'b1;
        wait_q[p] <= 0;
      end else if (wait_q[p] != 0) begin
        wait_q[p] <= wait_q[p] - 1;
      end
    end
  end
  // reference pulse for the sine generator, every 64 cycles.
  assign sine_o = (phase_q == 6'h00);
  assign done_o = done_q;
  // Off the done pulse the data wander, so a late capture cannot pass.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      if (!done_q[p]) data_o[14*p +: 14] = noise_q ^ 14'(p);
      else if (kind_q[p] == PPC_MEAS_VDC) data_o[14*p +: 14] = 14'h1a00 + offs_i;
      else data_o[14*p +: 14] = 14'h0500 + offs_i;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
/*
  Self-checking bench for the port protection control top level.
  Assumes a shortened fault tick set by a parameter; conversion timing comes from the port model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ppc_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0] mux;
    logic p1;
    logic [2:0] offn;
    logic [3:0] gate;
  } ppc_tb_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i, ce_i, por_n_i, ext_reset_n_i, auto_mode_i, port1_or_muxed_off_n_i;
  logic supplies_ok_i, bus_busy_i, sine_zero_i, hsel, hwrite, hready, slow;
  logic [2:0] port_off_n_i, hsize;
  logic [3:0] over_cut_i, in_foldback_i, fast_overload_i, ac_high_z_i, adc_done_i;
  logic [55:0] adc_data_i;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [13:0] offs;
  logic hreadyout, hresp, int_out_o, int_oe_n_o, auto_mode_o;
  logic [3:0] pass_gate_drive_o, adc_start_o, detect_level_hi_o, double_power_profile_o;
  logic [7:0] adc_meas_o;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0, vi_cnt = 0, iac_cnt = 0;
  ppc_tb_row_t rows [7] = '{'{32'h0f, 4'h0, 1'b1, 3'h7, 4'hf}, '{32'h0f, 4'h0, 1'b0, 3'h7, 4'he},
    '{32'h0f, 4'h0, 1'b1, 3'h2, 4'h5}, '{32'h1f, 4'h6, 1'b0, 3'h7, 4'h9},
    '{32'h1f, 4'h6, 1'b1, 3'h7, 4'hf}, '{32'h1f, 4'hf, 1'b0, 3'h7, 4'h0},
    '{32'h0f, 4'h0, 1'b0, 3'h0, 4'h0}};
  ppc_top #(.CONV_CYC(400), .SAMPLE_CYC(350), .FAULT_TICK_CYC(16)) uut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .por_n_i(por_n_i), .ext_reset_n_i(ext_reset_n_i),
    .auto_mode_i(auto_mode_i), .port1_or_muxed_off_n_i(port1_or_muxed_off_n_i),
    .port_off_n_i(port_off_n_i), .supplies_ok_i(supplies_ok_i), .over_cut_i(over_cut_i),
    .in_foldback_i(in_foldback_i), .fast_overload_i(fast_overload_i),
    .ac_high_z_i(ac_high_z_i), .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
    .sine_zero_i(sine_zero_i), .bus_busy_i(bus_busy_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pass_gate_drive_o(pass_gate_drive_o), .adc_start_o(adc_start_o),
    .adc_meas_o(adc_meas_o), .detect_level_hi_o(detect_level_hi_o),
    .double_power_profile_o(double_power_profile_o), .int_out_o(int_out_o),
    .int_oe_n_o(int_oe_n_o), .auto_mode_o(auto_mode_o));
  ppc_port_model model (.clk_i(clk_i), .start_i(adc_start_o), .meas_i(adc_meas_o),
    .slow_i(slow), .offs_i(offs), .data_o(adc_data_i), .done_o(adc_done_i),
    .sine_o(sine_zero_i));
  assign hready = hreadyout;
  always #4 clk_i = ~clk_i;
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (adc_start_o[0] && adc_meas_o[1:0] == PPC_MEAS_IAC) iac_cnt++;
    else if (adc_start_o[0] && adc_meas_o[1:0] != PPC_MEAS_DET) vi_cnt++;
    if (cycles == 90000) begin
      fails++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // The slave answers at once, yet each phase still waits on hready.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic gate(input logic [3:0] exp);
    check({28'h0, pass_gate_drive_o}, {28'h0, exp});
  endtask
  initial begin
    {rst_n_i, ce_i, por_n_i, ext_reset_n_i, auto_mode_i} = 5'b01110;
    {port1_or_muxed_off_n_i, port_off_n_i, supplies_ok_i, bus_busy_i} = 6'b111110;
    {over_cut_i, in_foldback_i, fast_overload_i, ac_high_z_i} = 16'h0000;
    {hsel, hwrite, haddr, htrans, hwdata, slow, offs} = '0;
    hsize = 3'b010;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    gate(4'h0);
    check({31'h0, int_oe_n_o}, 32'h1);
    bus(1'b0, 32'(PPC_REG_CTRL), 32'h0);
    check(rd, PPC_CTRL_RESET);
    bus(1'b1, 32'h40, 32'hffffffff);
    bus(1'b0, 32'h40, 32'h0);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, 32'(PPC_REG_MUXCFG), {28'h0, rows[i].mux});
      bus(1'b0, 32'(PPC_REG_MUXCFG), 32'h0);
      check(rd, {28'h0, rows[i].mux});
      bus(1'b1, 32'(PPC_REG_CTRL), rows[i].ctrl);
      port1_or_muxed_off_n_i <= rows[i].p1;
      port_off_n_i <= rows[i].offn;
      cyc(300);
      gate(rows[i].gate);
      bus(1'b1, 32'(PPC_REG_CTRL), 32'h0);
      port1_or_muxed_off_n_i <= 1'b1;
      port_off_n_i <= 3'h7;
      cyc(300);
    end
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h0e);
    cyc(300);
    port_off_n_i <= 3'h6;
    cyc(100);
    port_off_n_i <= 3'h7;
    cyc(300);
    gate(4'he);
    supplies_ok_i <= 1'b0;
    cyc(5);
    gate(4'h0);
    supplies_ok_i <= 1'b1;
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h1001);
    vi_cnt = 0;
    cyc(900);
    check(32'(vi_cnt), 32'h0);
    check({28'h0, double_power_profile_o}, 32'h0);
    cyc(2100);
    check(32'(vi_cnt >= 2), 32'h1);
    check({28'h0, double_power_profile_o}, 32'h1);
    bus(1'b0, 32'(PPC_REG_RESULT0), 32'h0);
    check(rd, {2'b0, 14'h0500, 2'b0, 14'h1a00});
    slow <= 1'b1;
    offs <= 14'h0011;
    cyc(1500);
    bus(1'b0, 32'(PPC_REG_RESULT0), 32'h0);
    check(rd, {2'b0, 14'h0511, 2'b0, 14'h1a11});
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h0);
    offs <= 14'h0022;
    cyc(1500);
    bus(1'b0, 32'(PPC_REG_RESULT0), 32'h0);
    check(rd, {2'b0, 14'h0511, 2'b0, 14'h1a11});
    iac_cnt = 0;
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h101);
    cyc(3000);
    check(32'(iac_cnt > 0), 32'h1);
    ac_high_z_i <= 4'h1;
    cyc(2000);
    gate(4'h0);
    ac_high_z_i <= 4'h0;
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h0);
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h1);
    over_cut_i <= 4'h1;
    cyc(1300);
    gate(4'h0);
    check({31'h0, int_oe_n_o}, 32'h0);
    over_cut_i <= 4'h0;
    bus_busy_i <= 1'b1;
    bus(1'b1, 32'(PPC_REG_INT), 32'hffffffff);
    cyc(4);
    check({31'h0, int_oe_n_o}, 32'h0);
    bus_busy_i <= 1'b0;
    cyc(4);
    check({31'h0, int_oe_n_o}, 32'h1);
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h0);
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h1);
    cyc(20);
    gate(4'h0);
    cyc(16000);
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h0);
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h1);
    cyc(1200);
    gate(4'h1);
    fast_overload_i <= 4'h1;
    cyc(1);
    fast_overload_i <= 4'h0;
    cyc(12300);
    gate(4'h0);
    cyc(400);
    gate(4'h1);
    por_n_i <= 1'b0;
    cyc(5);
    gate(4'h0);
    por_n_i <= 1'b1;
    bus(1'b0, 32'(PPC_REG_CTRL), 32'h0);
    check(rd, PPC_CTRL_RESET);
    check({31'h0, auto_mode_o}, 32'h0);
    bus(1'b1, 32'(PPC_REG_CTRL), 32'h0f);
    auto_mode_i <= 1'b1;
    ext_reset_n_i <= 1'b0;
    cyc(300);
    gate(4'h0);
    ext_reset_n_i <= 1'b1;
    cyc(400);
    check({31'h0, auto_mode_o}, 32'h1);
    auto_mode_i <= 1'b0;
    cyc(50);
    check({31'h0, auto_mode_o}, 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
